// ==== rtl/lpw_ctrl.sv ====
// Low-power mode sequencer with wake-up edge detection and supply reset hold.
// Assumes a software port with one-cycle read latency and wake sources that may be asynchronous.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////
module lpw_ctrl
   import lpw_pkg::*;
#(
   parameter int  NLINES   = 16,
   parameter int  STBY_CYC = STBY_WAKE_CYC
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [3:0]        addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [31:0]       rdata,
   input  wire logic [NLINES-1:0] ext_event_lines,
   input  wire logic [2:0]        wake_pin,
   input  wire logic              reset_pin,
   input  wire logic              independent_watchdog,
   input  wire logic [4:0]        cal_events,
   input  wire logic              deep_sleep_req,
   input  wire logic              periph_fast_osc_req,
   input  wire logic              por_above,
   input  wire logic [4:0]        bor_level_ok,
   input  wire logic [2:0]        opt_bor_level,
   output logic                   core_rst_ff,
   output logic                   core_clk_en_ff,
   output logic                   core_pwr_en_ff,
   output logic                   regulator_lp_ff,
   output logic                   pll_en_ff,
   output logic                   fast_rc_osc_en_ff,
   output logic                   fast_crystal_osc_en_ff,
   output logic                   multispeed_rc_osc_en_ff,
   output logic                   slow_osc_en_ff,
   output logic                   internal_ref_voltage_en_ff,
   output logic                   flash_dma_en_ff,
   output logic                   flash_wait_states_ff,
   output logic                   freq_error_ff,
   output logic                   wake_done_ff
);
   import lpw_pkg::*;

   localparam int NS = NLINES + 9;
   // Wake counts are shortened by the cycles spent in the synchroniser, edge detect,
   // option reload and output flops, so the core clock returns inside the latency limit
   localparam int STOP_LOAD = STOP_WAKE_CYC - 5;
   localparam int STBY_LOAD = (STBY_CYC > OPT_LOAD_CYC + 7) ? STBY_CYC - OPT_LOAD_CYC - 7 : 0;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Synchronised inputs
   logic [NS-1:0] raw;
   logic [NS-1:0] sync;
   logic [NS-1:0] prev_ff;
   assign raw = {cal_events, independent_watchdog, wake_pin, ext_event_lines};

   lpw_sync #(.W(NS)) u_sync (
      .clock (clock),
      .rst   (rst),
      .din   (raw),
      .dout  (sync)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) prev_ff <= '0;
      else prev_ff <= sync;
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0]       ctrl_ff;
   logic [NLINES-1:0] rise_ff;
   logic [NLINES-1:0] fall_ff;
   logic [NLINES-1:0] mask_ff;
   logic [NLINES-1:0] pend_ff;
   logic [3:0]        csr_ff;
   logic [2:0]        bor_sel_ff;
   lpw_state_t        state_ff;
   logic [15:0]       cnt_ff;
   logic              stby_ff;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic s);
      hit = s && (a == off);
   endfunction

   // Control survives standby because it sits in the always-on domain here
   always_ff @(posedge clock or posedge rst) begin
      if (rst) ctrl_ff <= CTRL_RST;
      else if (hit(addr, REG_CTRL, wr)) ctrl_ff <= wdata;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rise_ff <= RISE_RST[NLINES-1:0];
         fall_ff <= FALL_RST[NLINES-1:0];
         mask_ff <= MASK_RST[NLINES-1:0];
      end else if (stby_ff) begin
         // Core-domain settings are lost in Standby
         rise_ff <= RISE_RST[NLINES-1:0];
         fall_ff <= FALL_RST[NLINES-1:0];
         mask_ff <= MASK_RST[NLINES-1:0];
      end else begin
         if (hit(addr, REG_RISE, wr)) rise_ff <= wdata[NLINES-1:0];
         if (hit(addr, REG_FALL, wr)) fall_ff <= wdata[NLINES-1:0];
         if (hit(addr, REG_MASK, wr)) mask_ff <= wdata[NLINES-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Edge detection and pending flags
   logic [NLINES-1:0] line_ev;
   genvar g;
   generate
      for (g = 0; g < NLINES; g++) begin : g_edge
         assign line_ev[g] = mask_ff[g] &
            ((rise_ff[g] & sync[g] & ~prev_ff[g]) | (fall_ff[g] & ~sync[g] & prev_ff[g]));
      end
   endgenerate

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend_ff <= '0;
      end else if (stby_ff) begin
         // Flags live in the core domain, so Standby drops them like the edge settings
         pend_ff <= '0;
      end else begin
         pend_ff <= (pend_ff & ~(hit(addr, REG_PEND, wr) ? wdata[NLINES-1:0] : '0)) | line_ev;
      end
   end

   logic [2:0] pin_rise;
   logic       wdg_ev;
   logic       cal_ev;
   logic       stop_wake;
   logic       stby_wake;
   assign pin_rise  = sync[NLINES+2:NLINES] & ~prev_ff[NLINES+2:NLINES];
   assign wdg_ev    = sync[NLINES+3];
   assign cal_ev    = |sync[NS-1:NLINES+4];
   assign stop_wake = |line_ev;
   // Without the calendar only pins and the reset pin wake standby
   assign stby_wake = (|pin_rise) | (ctrl_ff[CTRL_KEEP_CAL] & (wdg_ev | cal_ev));

   //////////////////////////////////////////////////////////////////////////////////////////
   // Supply supervisor: brown-out level and reset hold
   // One ok bit per threshold; codes 5 and 6 match none and keep the device in reset
   logic supply_ok;
   assign supply_ok = por_above &&
      (bor_sel_ff == BOR_OFF || (bor_sel_ff < BOR_LEVELS && bor_level_ok[bor_sel_ff]));

   //////////////////////////////////////////////////////////////////////////////////////////
   // Mode sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff   <= ST_POR;
         cnt_ff     <= '0;
         bor_sel_ff <= 3'h0;
         stby_ff    <= 1'b0;
      end else if (!supply_ok || !reset_pin) begin
         state_ff <= ST_POR;
         cnt_ff   <= '0;
         stby_ff  <= 1'b0;
      end else begin
         case (state_ff)
            ST_POR: begin
               state_ff <= ST_OPTLOAD;
               cnt_ff   <= 16'(OPT_LOAD_CYC);
            end
            ST_OPTLOAD: begin
               if (cnt_ff == 16'h0000) begin
                  bor_sel_ff <= opt_bor_level;
                  state_ff   <= ST_RUN;
               end else cnt_ff <= cnt_ff - 16'h0001;
            end
            ST_RUN: begin
               if (deep_sleep_req && ctrl_ff[CTRL_DEEP]) begin
                  if (ctrl_ff[CTRL_STBY]) begin
                     state_ff <= ST_STBY;
                     stby_ff  <= 1'b1;
                  end else state_ff <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (stop_wake) begin
                  state_ff <= ST_WAKE;
                  cnt_ff   <= 16'(STOP_LOAD);
               end
            end
            ST_STBY: begin
               if (stby_wake) begin
                  state_ff <= ST_WAKE;
                  cnt_ff   <= 16'(STBY_LOAD);
               end
            end
            ST_WAKE: begin
               // Stays short of the latency limit; a later source is absorbed here
               if (cnt_ff == 16'h0000) begin
                  state_ff <= stby_ff ? ST_POR : ST_RUN;
                  stby_ff  <= 1'b0;
               end else cnt_ff <= cnt_ff - 16'h0001;
            end
            default: state_ff <= ST_POR;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Power and clock gating outputs
   logic in_stop;
   logic in_stby;
   logic run;
   assign in_stop = state_ff == ST_STOP;
   assign in_stby = stby_ff;
   assign run     = state_ff == ST_RUN;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         core_rst_ff                <= 1'b1;
         core_clk_en_ff             <= 1'b0;
         core_pwr_en_ff             <= 1'b1;
         regulator_lp_ff            <= 1'b0;
         pll_en_ff                  <= 1'b0;
         fast_rc_osc_en_ff          <= 1'b0;
         fast_crystal_osc_en_ff     <= 1'b0;
         multispeed_rc_osc_en_ff    <= 1'b0;
         slow_osc_en_ff             <= 1'b1;
         internal_ref_voltage_en_ff <= 1'b1;
         flash_dma_en_ff            <= 1'b0;
      end else begin
         core_rst_ff             <= state_ff == ST_POR || state_ff == ST_OPTLOAD;
         core_clk_en_ff          <= run;
         core_pwr_en_ff          <= !in_stby;
         regulator_lp_ff         <= in_stop;
         pll_en_ff               <= run;
         fast_rc_osc_en_ff       <= run || (in_stop && periph_fast_osc_req);
         fast_crystal_osc_en_ff  <= run;
         multispeed_rc_osc_en_ff <= !(in_stop || in_stby);
         // Slow oscillator kept for calendar and watchdog, except calendar-less standby
         slow_osc_en_ff          <= !(in_stby && !ctrl_ff[CTRL_KEEP_CAL]);
         internal_ref_voltage_en_ff <= !(in_stop && ctrl_ff[CTRL_REF_OFF]) && !in_stby;
         flash_dma_en_ff         <= run;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Voltage range check and flash wait states
   logic [1:0] rng;
   logic [8:0] freq;
   assign rng  = ctrl_ff[CTRL_RANGE_LSB +: 2];
   assign freq = ctrl_ff[CTRL_FREQ_LSB +: 9];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flash_wait_states_ff <= 1'b0;
         freq_error_ff        <= 1'b0;
      end else begin
         case (rng)
            RANGE1: begin
               flash_wait_states_ff <= freq > F_16M;
               freq_error_ff        <= freq > F_32M;
            end
            RANGE2: begin
               flash_wait_states_ff <= freq > F_8M;
               freq_error_ff        <= freq > F_16M;
            end
            RANGE3: begin
               flash_wait_states_ff <= 1'b0;
               freq_error_ff        <= freq > F_4M2;
            end
            default: begin
               flash_wait_states_ff <= 1'b1;
               freq_error_ff        <= 1'b1;
            end
         endcase
      end
   end

   // Clock-reset status: sticky causes of the last wake or reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) csr_ff <= 4'h0;
      else csr_ff <= (csr_ff & ~(hit(addr, REG_CSR, wr) ? wdata[3:0] : 4'h0)) |
                     {state_ff == ST_STBY && stby_wake, !reset_pin, wdg_ev, !supply_ok};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) wake_done_ff <= 1'b0;
      else wake_done_ff <= state_ff == ST_WAKE && cnt_ff == 16'h0000 && !stby_ff;
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Read port
   always_ff @(posedge clock or posedge rst) begin
      if (rst) rdata <= 32'h0000_0000;
      else if (rd) begin
         case (addr)
            REG_CTRL:   rdata <= ctrl_ff;
            REG_RISE:   rdata <= 32'(rise_ff);
            REG_FALL:   rdata <= 32'(fall_ff);
            REG_MASK:   rdata <= 32'(mask_ff);
            REG_PEND:   rdata <= 32'(pend_ff);
            REG_STATUS: rdata <= {29'h0000_0000, state_ff};
            REG_CSR:    rdata <= {28'h000_0000, csr_ff};
            REG_OPT:    rdata <= {29'h0000_0000, bor_sel_ff};
            default:    rdata <= 32'h0000_0000;
         endcase
      end else rdata <= 32'h0000_0000;
   end
endmodule
`default_nettype wire

// ==== rtl/lpw_pkg.sv ====
// Constants for the low-power mode and wake-up controller.
// Assumes a 100 MHz system clock and a software port with one-cycle reads.
package lpw_pkg;

   localparam int CLK_MHZ = 100;

   // Wake latencies, in nanoseconds, and their longest cycle counts
   localparam int STOP_WAKE_NS    = 3500;
   localparam int STOP_WAKE_CYC   = STOP_WAKE_NS * CLK_MHZ / 1000;
   localparam int STBY_WAKE_NS    = 60000;
   localparam int STBY_WAKE_CYC   = STBY_WAKE_NS * CLK_MHZ / 1000;

   // Option-byte load duration in cycles
   localparam int OPT_LOAD_CYC    = 16;

   // Register offsets
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_RISE    = 4'h1;
   localparam logic [3:0] REG_FALL    = 4'h2;
   localparam logic [3:0] REG_MASK    = 4'h3;
   localparam logic [3:0] REG_PEND    = 4'h4;
   localparam logic [3:0] REG_STATUS  = 4'h5;
   localparam logic [3:0] REG_CSR     = 4'h6;
   localparam logic [3:0] REG_OPT     = 4'h7;

   // Control register fields
   localparam int CTRL_DEEP       = 0;
   localparam int CTRL_STBY       = 1;
   localparam int CTRL_KEEP_CAL   = 2;
   localparam int CTRL_REF_OFF    = 3;
   localparam int CTRL_RANGE_LSB  = 4;
   localparam int CTRL_FREQ_LSB   = 8;

   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
   localparam logic [31:0] RISE_RST  = 32'h0000_0000;
   localparam logic [31:0] FALL_RST  = 32'h0000_0000;
   localparam logic [31:0] MASK_RST  = 32'h0000_0000;

   // Brown-out threshold codes, 1.8 V up to 3 V
   localparam logic [2:0] BOR_LEVELS = 3'h5;
   localparam logic [2:0] BOR_OFF    = 3'h7;

   // Voltage range codes and frequency limits in 100 kHz units
   localparam logic [1:0] RANGE1 = 2'h1;
   localparam logic [1:0] RANGE2 = 2'h2;
   localparam logic [1:0] RANGE3 = 2'h3;
   localparam logic [8:0] F_32M   = 9'h140;
   localparam logic [8:0] F_16M   = 9'h0A0;
   localparam logic [8:0] F_8M    = 9'h050;
   localparam logic [8:0] F_4M2   = 9'h02A;

   typedef enum logic [2:0] {
      ST_POR,
      ST_OPTLOAD,
      ST_RUN,
      ST_STOP,
      ST_STBY,
      ST_WAKE
   } lpw_state_t;

endpackage

// ==== rtl/lpw_sync.sv ====
// Two-flop synchroniser bank for wake-up inputs.
// Assumes inputs may be asynchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module lpw_sync #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_ff;

   // First stage feeds only the second
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         dout    <= '0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ==== sim/lpw_ctrl_chk.sv ====
// Port checker for the low-power sequencer.
// Assumes it is bound to lpw_ctrl and that the block has one clock domain.
`timescale 1ns/100ps
`default_nettype none
module lpw_ctrl_chk
   import lpw_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        reset_pin,
   input wire logic        por_above,
   input wire logic        periph_fast_osc_req,
   input wire logic        core_rst_ff,
   input wire logic        core_clk_en_ff,
   input wire logic        core_pwr_en_ff,
   input wire logic        regulator_lp_ff,
   input wire logic        pll_en_ff,
   input wire logic        fast_rc_osc_en_ff,
   input wire logic        fast_crystal_osc_en_ff,
   input wire logic        multispeed_rc_osc_en_ff,
   input wire logic        flash_dma_en_ff,
   input wire logic        wake_done_ff
);
   // Regulator drops one cycle into the wake; the pulse must still land inside the stop latency
   localparam int WK_MAX = STOP_WAKE_CYC - 5;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////////////////////
   a_stop_clk_off: assert property (regulator_lp_ff |->
      !(core_clk_en_ff | pll_en_ff | fast_crystal_osc_en_ff | multispeed_rc_osc_en_ff))
      else $error("clock running in stop");
   a_fast_rc_gate: assert property (regulator_lp_ff && $past(regulator_lp_ff, 2) &&
      !$past(periph_fast_osc_req) && !$past(periph_fast_osc_req, 2) |-> !fast_rc_osc_en_ff)
      else $error("fast rc on in stop without request");
   a_stop_wake_time: assert property ($fell(regulator_lp_ff) |-> ##[1:WK_MAX] wake_done_ff)
      else $error("stop wake too slow");
   a_wake_one_pulse: assert property (wake_done_ff |=> !wake_done_ff)
      else $error("wake done longer than a cycle");
   a_stby_osc_off: assert property (!core_pwr_en_ff |->
      !(core_clk_en_ff | pll_en_ff | fast_rc_osc_en_ff | fast_crystal_osc_en_ff | multispeed_rc_osc_en_ff))
      else $error("fast clocks on in standby");
   a_flash_dma_off: assert property (regulator_lp_ff || !core_pwr_en_ff |-> !flash_dma_en_ff)
      else $error("flash or dma on in deep sleep");
   a_pin_holds_rst: assert property (!reset_pin [*4] |-> core_rst_ff)
      else $error("reset pin low but core out of reset");
   a_supply_rst: assert property (!por_above [*4] |-> core_rst_ff)
      else $error("supply low but core out of reset");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data without read");
endmodule
`default_nettype wire

// ==== sim/lpw_far.sv ====
// Core-side model: raises the deep-sleep request on a bench command.
// Assumes the bench pulses sleep_cmd only while the core runs.
`timescale 1ns/100ps
`default_nettype none
module lpw_far (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic sleep_cmd,
   input  wire logic core_pwr_en_ff,
   input  wire logic regulator_lp_ff,
   output logic      deep_sleep_req
);
   // Held until the device is down, as a parked core would; dropping early would hide a slow entry
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         deep_sleep_req <= 1'b0;
      end else if (sleep_cmd) begin
         deep_sleep_req <= 1'b1;
      end else if (regulator_lp_ff || !core_pwr_en_ff) begin
         deep_sleep_req <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== sim/lpw_ctrl_tb.sv ====
// Self-checking bench for the low-power sequencer.
// Assumes the package constants and a short standby exit count.
`timescale 1ns/100ps
`default_nettype none
module lpw_ctrl_tb;
   import lpw_pkg::*;
   localparam int SCYC = 20;
   logic        clock, rst, wr, rd, reset_pin, independent_watchdog, deep_sleep_req, sleep_cmd;
   logic        periph_fast_osc_req, por_above, core_rst_ff, core_clk_en_ff, core_pwr_en_ff;
   logic        regulator_lp_ff, pll_en_ff, fast_rc_osc_en_ff, fast_crystal_osc_en_ff;
   logic        multispeed_rc_osc_en_ff, slow_osc_en_ff, internal_ref_voltage_en_ff, flash_dma_en_ff;
   logic        flash_wait_states_ff, freq_error_ff, wake_done_ff;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, d;
   logic [15:0] ext_event_lines;
   logic [2:0]  wake_pin, opt_bor_level;
   logic [4:0]  cal_events, bor_level_ok;
   int          n_fail, tests_run, i, n;
   int          n_wake = 0;
   // Range, wait state, error, frequency
   logic [12:0] ft [9] = '{{RANGE1, 2'b00, F_4M2}, {RANGE1, 2'b00, F_16M}, {RANGE1, 2'b10, F_16M + 9'h001},
      {RANGE1, 2'b10, F_32M}, {RANGE2, 2'b10, F_16M}, {RANGE2, 2'b00, F_8M}, {RANGE2, 2'b10, F_8M + 9'h001},
      {RANGE3, 2'b00, F_4M2}, {RANGE3, 2'b01, F_4M2 + 9'h001}};
   logic [2:0]  so_opt [5] = '{3'h7, 3'h2, 3'h2, 3'h4, 3'h5};
   logic [4:0]  so_ok [5] = '{5'h00, 5'h03, 5'h1F, 5'h0F, 5'h1F};
   logic        so_rst [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   lpw_ctrl #(.NLINES(16), .STBY_CYC(SCYC)) dut_u (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .ext_event_lines, .wake_pin, .reset_pin, .independent_watchdog, .cal_events, .deep_sleep_req,
      .periph_fast_osc_req, .por_above, .bor_level_ok, .opt_bor_level, .core_rst_ff, .core_clk_en_ff,
      .core_pwr_en_ff, .regulator_lp_ff, .pll_en_ff, .fast_rc_osc_en_ff, .fast_crystal_osc_en_ff,
      .multispeed_rc_osc_en_ff, .slow_osc_en_ff, .internal_ref_voltage_en_ff, .flash_dma_en_ff,
      .flash_wait_states_ff, .freq_error_ff, .wake_done_ff);
   lpw_far far_u (.clock, .rst, .sleep_cmd, .core_pwr_en_ff, .regulator_lp_ff, .deep_sleep_req);
   //////////////////////////////////////////////////////////////////////////////
   always #5 clock = ~clock;
   always @(posedge clock) if (wake_done_ff === 1'b1) n_wake <= n_wake + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t ns: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string m);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
      chk(d, exp, m);
   endtask
   // Polls the state field; the read port keeps working while the core sleeps
   task automatic wait_st(input logic [31:0] s, input int lim);
      for (int k = 0; k < lim; k++) begin
         @(posedge clock);
         addr <= REG_STATUS;
         rd <= 1'b1;
         @(posedge clock);
         rd <= 1'b0;
         #1;
         if (rdata === s) break;
      end
      chk(rdata, s, "state");
   endtask
   task automatic sleep();
      @(posedge clock);
      sleep_cmd <= 1'b1;
      @(posedge clock);
      sleep_cmd <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   task automatic set_ev(input logic [15:0] v);
      @(posedge clock);
      ext_event_lines <= v;
      repeat (5) @(posedge clock);
   endtask
   // Sources 0-2 wake pins, 3-7 calendar events, 8 watchdog, 9 reset pin
   task automatic fire(input int s);
      @(posedge clock);
      if (s < 3) wake_pin[s] <= 1'b1;
      else if (s < 8) cal_events[s-3] <= 1'b1;
      else if (s == 8) independent_watchdog <= 1'b1;
      else reset_pin <= 1'b0;
      repeat (8) @(posedge clock);
      wake_pin <= 3'h0;
      cal_events <= 5'h00;
      independent_watchdog <= 1'b0;
      reset_pin <= 1'b1;
   endtask
   task automatic conclude();
      $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #500_000;
      n_fail++;
      $display("Error at %0t ns: run hung", $time);
      conclude();
   end
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0; rst = 1'b1; addr = 4'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
      ext_event_lines = 16'h0; wake_pin = 3'h0; reset_pin = 1'b1; independent_watchdog = 1'b0;
      cal_events = 5'h00; sleep_cmd = 1'b0; periph_fast_osc_req = 1'b0; por_above = 1'b1;
      bor_level_ok = 5'h1F; opt_bor_level = 3'h0; n_fail = 0; tests_run = 0;
      repeat (2) @(posedge clock);
      chk({core_rst_ff, core_pwr_en_ff, slow_osc_en_ff, internal_ref_voltage_en_ff}, 32'hF, "rst on");
      chk({core_clk_en_ff, regulator_lp_ff, pll_en_ff, fast_rc_osc_en_ff, flash_dma_en_ff}, 32'h0, "rst off");
      rst <= 1'b0;
      wait_st(ST_RUN, 20);
      chk(core_rst_ff, 32'h0, "core reset after load");
      rd_chk(REG_CTRL, CTRL_RST, "ctrl");
      rd_chk(REG_RISE, RISE_RST, "rise");
      rd_chk(REG_FALL, FALL_RST, "fall");
      rd_chk(REG_MASK, MASK_RST, "mask");
      rd_chk(4'h9, 32'h0, "unmapped");
      $display("Test reset finished");
      // Steps stay under four times the last and 5 us apart; range 1 assumes a supply above 1.71 V
      for (i = 0; i < 9; i++) begin
         wr_reg(REG_CTRL, 32'({ft[i][8:0], 2'b00, ft[i][12:11], 4'h0}));
         repeat (3) @(posedge clock);
         chk(freq_error_ff, ft[i][9], "freq error");
         if (!ft[i][9]) chk(flash_wait_states_ff, ft[i][10], "wait states");
         repeat (500) @(posedge clock);
      end
      $display("Test ranges finished");
      wr_reg(REG_RISE, 32'h5);
      wr_reg(REG_FALL, 32'h6);
      wr_reg(REG_MASK, 32'h7);
      set_ev(16'h0003);
      rd_chk(REG_PEND, 32'h1, "rise only");
      set_ev(16'h0000);
      rd_chk(REG_PEND, 32'h3, "fall");
      wr_reg(REG_PEND, 32'h3);
      set_ev(16'h0004);
      rd_chk(REG_PEND, 32'h4, "both rise");
      wr_reg(REG_PEND, 32'h4);
      set_ev(16'h0000);
      rd_chk(REG_PEND, 32'h4, "both fall");
      wr_reg(REG_PEND, 32'h4);
      set_ev(16'h0008);
      set_ev(16'h0000);
      rd_chk(REG_PEND, 32'h0, "masked");
      $display("Test edges finished");
      wr_reg(REG_CTRL, CTRL_RST | 32'h9);
      sleep();
      rd_chk(REG_STATUS, ST_STOP, "enter stop");
      chk(regulator_lp_ff, 32'h1, "regulator");
      chk(internal_ref_voltage_en_ff, 32'h0, "ref off");
      @(posedge clock);
      periph_fast_osc_req <= 1'b1;
      repeat (4) @(posedge clock);
      chk(fast_rc_osc_en_ff, 32'h1, "fast rc request");
      periph_fast_osc_req <= 1'b0;
      set_ev(16'h0008);
      set_ev(16'h0000);
      rd_chk(REG_STATUS, ST_STOP, "masked wake");
      n = n_wake;
      set_ev(16'h0005);
      wait_st(ST_RUN, 200);
      chk(n_wake, n + 1, "single wake");
      rd_chk(REG_CTRL, CTRL_RST | 32'h9, "kept ctrl");
      chk(internal_ref_voltage_en_ff, 32'h1, "ref back");
      set_ev(16'h0000);
      $display("Test stop finished");
      for (i = 0; i < 10; i++) begin
         wr_reg(REG_MASK, 32'h7);
         wr_reg(REG_CTRL, CTRL_RST | 32'h7);
         sleep();
         chk({core_pwr_en_ff, slow_osc_en_ff}, 32'h1, "standby power");
         fire(i);
         wait_st(ST_RUN, 60);
         rd_chk(REG_MASK, 32'h0, "lost mask");
         if (i == 0) rd_chk(REG_CSR, 32'h8, "standby flag");
         wr_reg(REG_CSR, 32'hF);
      end
      wr_reg(REG_CTRL, CTRL_RST | 32'h3);
      sleep();
      chk(slow_osc_en_ff, 32'h0, "slow osc off");
      fire(3);
      fire(8);
      repeat (60) @(posedge clock);
      chk(core_pwr_en_ff, 32'h0, "stays in standby");
      fire(1);
      wait_st(ST_RUN, 60);
      $display("Test standby finished");
      for (i = 0; i < 5; i++) begin
         @(posedge clock);
         por_above <= 1'b0;
         bor_level_ok <= 5'h1F;
         opt_bor_level <= so_opt[i];
         repeat (6) @(posedge clock);
         por_above <= 1'b1;
         repeat (40) @(posedge clock);
         bor_level_ok <= so_ok[i];
         repeat (40) @(posedge clock);
         chk(core_rst_ff, so_rst[i], "brown-out hold");
      end
      $display("Test supply finished");
      conclude();
   end
endmodule
bind lpw_ctrl lpw_ctrl_chk chk_u (.clock, .rst, .rd, .rdata, .reset_pin, .por_above, .periph_fast_osc_req,
   .core_rst_ff, .core_clk_en_ff, .core_pwr_en_ff, .regulator_lp_ff, .pll_en_ff, .fast_rc_osc_en_ff,
   .fast_crystal_osc_en_ff, .multispeed_rc_osc_en_ff, .flash_dma_en_ff, .wake_done_ff);
`default_nettype wire
